// *** rtl/dpvis_params.svh ***
`ifndef DPVIS_PARAMS_SVH
`define DPVIS_PARAMS_SVH
`define DPVIS_SHIFT_W      32
`define DPVIS_SYSDIV       2
`define DPVIS_FREEZE_CODE  2'h3
`define DPVIS_RSTOUT_CYC   16
`endif

// *** rtl/dpvis_pkg.sv ***
package dpvis_pkg;
  typedef struct packed {
    logic [2:0] fetch_visibility;
    logic [1:0] flush_count_out;
    logic [5:0] watchpoint;
  } dpvis_vis_t;

  typedef struct packed {
    logic data_bus_cfg;
    logic debug_enable;
  } dpvis_cfg_t;

  typedef enum logic [1:0] {
    DPVIS_RESET,
    DPVIS_RUN
  } dpvis_state_t;
endpackage

// *** rtl/dpvis_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser per bit; first stage feeds only the second
module dpvis_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // metastability guard
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // dpvis_sync
`default_nettype wire

// *** rtl/dpvis_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dpvis_params.svh"
module dpvis_top
  import dpvis_pkg::*;
#(
  parameter int SHIFT_W    = `DPVIS_SHIFT_W,
  parameter int RSTOUT_CYC = `DPVIS_RSTOUT_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               clocked_mode,
  input  wire logic               dbg_serial_in,
  input  wire logic               dbg_serial_clk,
  input  wire dpvis_vis_t         core_vis,
  input  wire logic               core_freeze,
  input  wire logic [SHIFT_W-1:0] tx_word,
  input  wire logic               tx_load,
  output var  logic               dbg_serial_out,
  output var  logic               system_clock_out,
  output var  logic               reset_indication_out,
  output var  dpvis_vis_t         vis_out,
  output var  dpvis_cfg_t         cfg_out,
  output var  logic [SHIFT_W-1:0] rx_word,
  output var  logic               rx_valid
);
  // counter widths carry one spare bit so that the terminal count
  // compares cleanly even when the count is a power of two
  // divider counter: counts clock cycles within each half period of the system clock output
  // reset stretch counter: counts cycles of the reset output window
  // bit counter: position within the current serial word
  localparam int DIVW = $clog2(`DPVIS_SYSDIV) + 1;
  localparam int RCW  = $clog2(RSTOUT_CYC) + 1;
  localparam int BCW  = $clog2(SHIFT_W) + 1;

  dpvis_state_t     state_q;
  logic [RCW-1:0]   rcnt_q;
  logic [DIVW-1:0]  div_q;
  logic             sclk_prev_q;
  logic [1:0]       pins_s;
  logic             sdi_s;
  logic             sck_s;
  logic             sck_prev_q;
  logic             shift_edge;
  logic             launch_edge;
  logic [SHIFT_W-1:0] sreg_q;
  logic [BCW-1:0]   bcnt_q;

  // pins come from the tool's domain, so synchronise both
  // data and clock share one synchroniser so that they keep their
  // relative timing; the tool must hold data about two cycles
  // before it moves the serial clock, or a bit can be taken early
  dpvis_sync #(
    .W (2)
  ) u_pin_sync (
    .clk (clk),
    .rst (rst),
    .d   ({dbg_serial_in, dbg_serial_clk}),
    .q   (pins_s)
  );
  assign sdi_s = pins_s[1];
  assign sck_s = pins_s[0];

  // system clock output divider, free running
  // it keeps toggling through reset windows so the tool always sees
  // a reference; the previous level is kept for edge detection,
  // which costs one cycle of latency on every self-clocked edge
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q            <= '0;
      system_clock_out <= 1'b0;
      sclk_prev_q      <= 1'b0;
    end else begin
      sclk_prev_q <= system_clock_out;
      if (div_q == DIVW'(`DPVIS_SYSDIV - 1)) begin
        div_q            <= '0;
        system_clock_out <= ~system_clock_out;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  // edge detect on the synchronised serial clock
  // the history flop resets low, matching the idle level of the pin,
  // so that no false rising edge follows reset
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end

  // rising edge shifts in, falling edge launches out
  // mode select is a level from the core; changing it mid word
  // mixes two clock sources, so software should switch only when idle
  always_comb begin
    if (clocked_mode) begin
      shift_edge  = sck_s & ~sck_prev_q;
      launch_edge = ~sck_s & sck_prev_q;
    end else begin
      shift_edge  = system_clock_out & ~sclk_prev_q;
      launch_edge = ~system_clock_out & sclk_prev_q;
    end
  end

  // reset output stretch: held a fixed time after rst, then released
  // the window gives the synchronised strap pins time to settle
  // before they are frozen; a shorter window would need fewer flops
  // on the pin path, which the metastability budget does not allow
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q              <= DPVIS_RESET;
      rcnt_q               <= '0;
      reset_indication_out <= 1'b1;
    end else begin
      case (state_q)
        DPVIS_RESET: begin
          if (rcnt_q == RCW'(RSTOUT_CYC - 1)) begin
            state_q              <= DPVIS_RUN;
            reset_indication_out <= 1'b0;
          end else begin
            rcnt_q <= rcnt_q + 1'b1;
          end
        end
        DPVIS_RUN: begin
          reset_indication_out <= 1'b0;
        end
        default: begin
          state_q              <= DPVIS_RESET;
          reset_indication_out <= 1'b1;
        end
      endcase
    end
  end

  // straps: sampled while reset output asserted, frozen at its release
  // the sample is taken at the last cycle of the window, the same
  // edge at which the reset output falls, and then held until the
  // next reset; strap levels that move later are ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_out <= '0;
    end else if (state_q == DPVIS_RESET) begin
      if (rcnt_q == RCW'(RSTOUT_CYC - 1)) begin
        cfg_out.data_bus_cfg <= sdi_s;
        cfg_out.debug_enable <= sck_s;
      end
    end
  end

  // shift register: in from serial input, out msb first
  // one register serves both directions: each rising edge pulls a
  // bit in at the bottom while the top bit has already been launched
  // on the previous falling edge; a load is taken only between words
  // so a word in flight is never cut
  always_ff @(posedge clk) begin
    if (rst) begin
      sreg_q         <= '0;
      bcnt_q         <= '0;
      rx_word        <= '0;
      rx_valid       <= 1'b0;
      dbg_serial_out <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (state_q != DPVIS_RUN) begin
        bcnt_q         <= '0;
        dbg_serial_out <= 1'b0;
      end else if (tx_load && bcnt_q == '0) begin
        sreg_q         <= tx_word;
        dbg_serial_out <= tx_word[SHIFT_W-1];
      end else begin
        if (launch_edge) begin
          dbg_serial_out <= sreg_q[SHIFT_W-1];
        end
        if (shift_edge) begin
          sreg_q <= {sreg_q[SHIFT_W-2:0], sdi_s};
          if (bcnt_q == BCW'(SHIFT_W - 1)) begin
            bcnt_q   <= '0;
            rx_word  <= {sreg_q[SHIFT_W-2:0], sdi_s};
            rx_valid <= 1'b1;
          end else begin
            bcnt_q <= bcnt_q + 1'b1;
          end
        end
      end
    end
  end

  // visibility registered every cycle, no bus alignment
  // one cycle of latency for clean pin timing; freeze takes the
  // flush count field so the tool can tell a stopped core apart
  always_ff @(posedge clk) begin
    if (rst) begin
      vis_out <= '0;
    end else begin
      vis_out.fetch_visibility <= core_vis.fetch_visibility;
      // freeze overrides the flush count code
      vis_out.flush_count_out  <= core_freeze ? `DPVIS_FREEZE_CODE
                                              : core_vis.flush_count_out;
      vis_out.watchpoint       <= core_vis.watchpoint;
    end
  end
endmodule // dpvis_top
`default_nettype wire

// *** sim/dpvis_top_props.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dpvis_params.svh"
module dpvis_top_props
  import dpvis_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       core_freeze,
  input wire dpvis_vis_t core_vis,
  input wire dpvis_vis_t vis_out,
  input wire dpvis_cfg_t cfg_out,
  input wire logic       reset_indication_out,
  input wire logic       rx_valid,
  input wire logic       system_clock_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // divider shape and reset window length
  sequence s_hi2; $rose(system_clock_out) ##1 system_clock_out; endsequence
  sequence s_rio16; reset_indication_out[*8] ##1 reset_indication_out[*8]; endsequence
  property p_sco; s_hi2 |=> !system_clock_out[*2] ##1 system_clock_out; endproperty
  property p_rio; $fell(rst) |-> s_rio16 ##[1:4] !reset_indication_out; endproperty
  property p_quiet; reset_indication_out |-> !rx_valid; endproperty
  property p_cfg; !reset_indication_out |=> $stable(cfg_out); endproperty
  property p_vf; 1 |=> vis_out.fetch_visibility == $past(core_vis.fetch_visibility); endproperty
  property p_frz; core_freeze |=> vis_out.flush_count_out == `DPVIS_FREEZE_CODE; endproperty
  property p_fls; !core_freeze |=> vis_out.flush_count_out == $past(core_vis.flush_count_out); endproperty
  property p_wp; 1 |=> vis_out.watchpoint == $past(core_vis.watchpoint); endproperty
  a_sco: assert property (p_sco) else $error("clock out shape");
  a_rio: assert property (p_rio) else $error("reset window");
  a_quiet: assert property (p_quiet) else $error("word in reset");
  a_cfg: assert property (p_cfg) else $error("cfg moved");
  a_vf: assert property (p_vf) else $error("fetch vis");
  a_frz: assert property (p_frz) else $error("freeze code");
  a_fls: assert property (p_fls) else $error("flush count");
  a_wp: assert property (p_wp) else $error("watchpoint");
endmodule // dpvis_top_props
`default_nettype wire

// *** sim/dpvis_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// debug tool: drives straps and clocked serial words
module dpvis_host_model (
  output var logic sck,
  output var logic sdi
);
  initial begin
    sck = 0;
    sdi = 0;
  end
  // straps held while reset output is high; clk strap low for normal runs
  task automatic strap(input logic d, input logic c);
    sdi = d;
    sck = c;
  endtask
  // msb first, data set half a period before rise, clock idles low
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      sdi = w[i];
      #80 sck = 1;
      #80 sck = 0;
    end
    sdi = ~sdi; // data not held past the frame
    #80;
  endtask
endmodule // dpvis_host_model
`default_nettype wire

// *** sim/tb_dpvis_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_dpvis_top;
  import dpvis_pkg::*;
  logic        clk = 0, rst = 1, clocked_mode = 1, core_freeze = 0, tx_load = 0;
  logic        sck, sdi, sdo, sco, rio, rx_valid;
  logic [31:0] tx_word = '0, rx_word, w;
  dpvis_vis_t  core_vis = '0, vis_out;
  dpvis_cfg_t  cfg_out;
  logic [31:0] exp_q[$];
  logic [31:0] sdo_sr = '0;
  // tool side samples serial out on its own rising clock edge
  always @(posedge sck) sdo_sr <= {sdo_sr[30:0], sdo};
  int          miscompares = 0, total_checks = 0;
  always #10 clk = ~clk;
  dpvis_host_model host_u (.sck(sck), .sdi(sdi));
  dpvis_top dut_u (.clk(clk), .rst(rst), .clocked_mode(clocked_mode), .dbg_serial_in(sdi), .dbg_serial_clk(sck),
    .core_vis(core_vis), .core_freeze(core_freeze), .tx_word(tx_word), .tx_load(tx_load), .dbg_serial_out(sdo),
    .system_clock_out(sco), .reset_indication_out(rio), .vis_out(vis_out), .cfg_out(cfg_out),
    .rx_word(rx_word), .rx_valid(rx_valid));
  task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_cfg(input dpvis_cfg_t e, input dpvis_cfg_t g);
    cmp_word({30'h0, e}, {30'h0, g});
  endtask
  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // strap pins held through the window, dropped after exit
  task automatic do_reset(input logic d, input logic c);
    @(negedge clk);
    rst = 1;
    host_u.strap(d, c);
    repeat (4) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 40 && rio !== 1'b0; i++) @(negedge clk);
    cmp_word(32'h0, {31'h0, rio});
    repeat (3) @(negedge clk);
    host_u.strap(1'b0, 1'b0);
    repeat (6) @(negedge clk);
    cmp_cfg({d, c}, cfg_out);
  endtask
  // random core activity each cycle, freeze included
  always @(negedge clk) begin
    core_vis <= dpvis_vis_t'($urandom);
    core_freeze <= 1'($urandom);
  end
  // a missing note makes a forced mismatch
  always @(negedge clk) begin
    if (rx_valid === 1'b1)
      cmp_word(exp_q.size() > 0 ? exp_q.pop_front() : ~rx_word, rx_word);
  end
  initial begin
    void'($urandom(47344));
    for (int s = 0; s < 4; s++) do_reset(s[1], s[0]);
    @(negedge clk);
    tx_word = $urandom;
    tx_load = 1;
    @(negedge clk);
    tx_load = 0;
    // three words back to back
    for (int n = 0; n < 3; n++) begin
      w = $urandom;
      exp_q.push_back(w);
      host_u.send(w);
      if (n == 0) cmp_word(tx_word, sdo_sr);
    end
    repeat (20) @(negedge clk);
    cmp_word(32'h0, 32'(exp_q.size()));
    finish_test();
  end
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
endmodule // tb_dpvis_top
bind dpvis_top dpvis_top_props props_u (.clk(clk), .rst(rst), .core_freeze(core_freeze), .core_vis(core_vis),
  .vis_out(vis_out), .cfg_out(cfg_out), .reset_indication_out(reset_indication_out), .rx_valid(rx_valid),
  .system_clock_out(system_clock_out));
`default_nettype wire
